// [common/pwr_tmr_pkg.sv]
// constants for the power and timer/external-irq control register bank
package pwr_tmr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_OFS        = 8'h87;
    localparam logic [7:0] TIMER_EXTIRQ_CONTROL_OFS = 8'h88;
    // ------------------------------------------------------------
    // power control field positions
    // ------------------------------------------------------------
    localparam int BAUD_DOUBLE_BIT   = 7;
    localparam int FE_SELECT_BIT     = 6;
    localparam int POWER_ON_FLAG_BIT = 4;
    localparam int GEN_FLAG_ONE_BIT  = 3;
    localparam int GEN_FLAG_ZERO_BIT = 2;
    localparam int POWER_DOWN_BIT    = 1;
    localparam int LIGHT_SLEEP_BIT   = 0;
    // ------------------------------------------------------------
    // timer / external irq control field positions
    // ------------------------------------------------------------
    localparam int T1_OVF_BIT  = 7;
    localparam int T1_RUN_BIT  = 6;
    localparam int T0_OVF_BIT  = 5;
    localparam int T0_RUN_BIT  = 4;
    localparam int X1_FLAG_BIT = 3;
    localparam int X1_TYPE_BIT = 2;
    localparam int X0_FLAG_BIT = 1;
    localparam int X0_TYPE_BIT = 0;
    // ------------------------------------------------------------
    // reset values and power control write mask
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0] TIMER_EXTIRQ_RST  = 8'h00;
    localparam logic [7:0] POWER_CONTROL_MSK = 8'hDF;
endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser plus falling-edge detector for one input pin
`timescale 1ns/1ps
module pin_sync
(
    input  wire logic core_clk,   // system clock
    input  wire logic rst_n,      // async reset, active low
    input  wire logic pin_in,     // raw pin level
    output logic      level_q,    // synchronised level
    output logic      fall        // one-cycle falling-edge pulse
);
    logic meta_q;                 // first stage, read only by level_q
    logic prev_q;                 // previous synchronised sample

    // ------------------------------------------------------------
    // synchroniser; resets high as pins idle high
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q  <= 1'b1;
            level_q <= 1'b1;
            prev_q  <= 1'b1;
        end
        else
        begin
            meta_q  <= pin_in;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

    // high then low on successive synchronised samples
    assign fall = prev_q & ~level_q;
endmodule

// [rtl/pwr_tmr_regs.sv]
// power control and timer/external-interrupt control register bank
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Function
// - baud double bit doubles serial port rate
// - bit 6 selects mode bit or framing flag
// - power-on flag set by power-on reset or a write of 1
// - bits 3 and 2 are plain flags
// - power-down bit stops all clocks
// - wake from power-down clears its bit
// - both bits set means power-down only
// - light-sleep bit stops cpu clock only
// - wake from light sleep clears its bit
// - timer1 overflow flag set, auto cleared
// - timer0 overflow flag set, auto cleared
// - bit 6 runs timer 1, clear holds count
// - bit 4 runs timer 0, clear holds count
// - type selects choose level or falling edge
// - irq1 edge flag sticky until cleared
// - irq1 level flag is inverted pin, read-only
// - irq0 edge flag sticky until cleared
// - irq0 level flag is inverted pin, read-only
// - timer/irq control resets to zero
module pwr_tmr_regs
    import pwr_tmr_pkg::*;
#(
    parameter int ADDR_W = 8      // register address width
)
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,          // any reset
    input  wire logic              por_n,          // power-on reset only
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              timer1_overflow, // overflow pulse
    input  wire logic              timer0_overflow,
    input  wire logic              timer1_isr_enter, // vector taken
    input  wire logic              timer0_isr_enter,
    input  wire logic              ext_irq1_isr_enter,
    input  wire logic              ext_irq0_isr_enter,
    input  wire logic              wake_event,      // any waking irq
    input  wire logic              ext_irq1_pin,
    input  wire logic              ext_irq0_pin,
    output logic                   serial_baud_double,
    output logic                   frame_error_access_select,
    output logic                   timer1_run,
    output logic                   timer0_run,
    output logic                   ext_irq1_flag,
    output logic                   ext_irq0_flag,
    output logic                   cpu_clk_stop,    // core frozen
    output logic                   periph_clk_stop  // peripherals off
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 8)
    begin : g_bad_width
        $error("ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] pctl_q;           // power control, bit 5 reserved
    logic       pof_q;            // power-on flag, own reset
    logic [7:0] tctl_q;           // timer/irq control, edge flags
    logic       x1_lvl;           // synchronised pin levels
    logic       x0_lvl;
    logic       x1_fall;          // falling-edge pulses
    logic       x0_fall;
    logic       wr_pctl;          // decoded write strobes
    logic       wr_tctl;
    logic [7:0] pctl_rd;          // assembled read views
    logic [7:0] tctl_rd;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    assign wr_pctl = reg_wr & hit(reg_addr, POWER_CONTROL_OFS);
    assign wr_tctl = reg_wr & hit(reg_addr, TIMER_EXTIRQ_CONTROL_OFS);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // synchronised edge detect
    pin_sync u_sync1
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (ext_irq1_pin),
        .level_q  (x1_lvl),
        .fall     (x1_fall)
    );

    pin_sync u_sync0
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (ext_irq0_pin),
        .level_q  (x0_lvl),
        .fall     (x0_fall)
    );

    // ------------------------------------------------------------
    // power-on flag: power-on reset or a write of 1 sets it
    // ------------------------------------------------------------
    // set by power-on, kept by others
    always_ff @(posedge core_clk or negedge por_n)
    begin
        if (!por_n)
            pof_q <= 1'b1;
        else if (wr_pctl)
            pof_q <= reg_wdata[POWER_ON_FLAG_BIT];
    end

    // ------------------------------------------------------------
    // power control register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pctl_q <= POWER_CONTROL_RST;
        else if (wr_pctl)
        begin
            pctl_q <= reg_wdata & POWER_CONTROL_MSK;
            if (reg_wdata[POWER_DOWN_BIT])
                pctl_q[LIGHT_SLEEP_BIT] <= 1'b0;
        end
        else if (wake_event)
        begin
            pctl_q[POWER_DOWN_BIT]  <= 1'b0;
            pctl_q[LIGHT_SLEEP_BIT] <= 1'b0;
        end
    end

    assign serial_baud_double        = pctl_q[BAUD_DOUBLE_BIT];
    assign frame_error_access_select = pctl_q[FE_SELECT_BIT];
    assign periph_clk_stop = pctl_q[POWER_DOWN_BIT];
    // light sleep stops only the core
    assign cpu_clk_stop    = pctl_q[POWER_DOWN_BIT]
                           | pctl_q[LIGHT_SLEEP_BIT];

    // ------------------------------------------------------------
    // timer / external irq control register
    // ------------------------------------------------------------
    // all zero after reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            tctl_q <= TIMER_EXTIRQ_RST;
        else
        begin
            // plain read/write bits
            if (wr_tctl)
            begin
                tctl_q[T1_RUN_BIT]  <= reg_wdata[T1_RUN_BIT];
                tctl_q[T0_RUN_BIT]  <= reg_wdata[T0_RUN_BIT];
                tctl_q[X1_TYPE_BIT] <= reg_wdata[X1_TYPE_BIT];
                tctl_q[X0_TYPE_BIT] <= reg_wdata[X0_TYPE_BIT];
            end
            if (timer1_overflow)
                tctl_q[T1_OVF_BIT] <= 1'b1;
            else if (wr_tctl)
                tctl_q[T1_OVF_BIT] <= reg_wdata[T1_OVF_BIT];
            else if (timer1_isr_enter)
                tctl_q[T1_OVF_BIT] <= 1'b0;
            if (timer0_overflow)
                tctl_q[T0_OVF_BIT] <= 1'b1;
            else if (wr_tctl)
                tctl_q[T0_OVF_BIT] <= reg_wdata[T0_OVF_BIT];
            else if (timer0_isr_enter)
                tctl_q[T0_OVF_BIT] <= 1'b0;
            if (tctl_q[X1_TYPE_BIT] && x1_fall)
                tctl_q[X1_FLAG_BIT] <= 1'b1;
            else if (wr_tctl && tctl_q[X1_TYPE_BIT])
                tctl_q[X1_FLAG_BIT] <= reg_wdata[X1_FLAG_BIT];
            else if (ext_irq1_isr_enter || !tctl_q[X1_TYPE_BIT])
                tctl_q[X1_FLAG_BIT] <= 1'b0;
            if (tctl_q[X0_TYPE_BIT] && x0_fall)
                tctl_q[X0_FLAG_BIT] <= 1'b1;
            else if (wr_tctl && tctl_q[X0_TYPE_BIT])
                tctl_q[X0_FLAG_BIT] <= reg_wdata[X0_FLAG_BIT];
            else if (ext_irq0_isr_enter || !tctl_q[X0_TYPE_BIT])
                tctl_q[X0_FLAG_BIT] <= 1'b0;
        end
    end

    assign timer1_run = tctl_q[T1_RUN_BIT];
    assign timer0_run = tctl_q[T0_RUN_BIT];

    // ------------------------------------------------------------
    // visible irq flags: level mode shows inverted pin
    // ------------------------------------------------------------
    // type select picks the source
    assign ext_irq1_flag = tctl_q[X1_TYPE_BIT] ? tctl_q[X1_FLAG_BIT]
                                               : ~x1_lvl;
    assign ext_irq0_flag = tctl_q[X0_TYPE_BIT] ? tctl_q[X0_FLAG_BIT]
                                               : ~x0_lvl;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb
    begin
        pctl_rd = pctl_q;
        pctl_rd[POWER_ON_FLAG_BIT] = pof_q;
        tctl_rd = tctl_q;
        tctl_rd[X1_FLAG_BIT] = ext_irq1_flag;
        tctl_rd[X0_FLAG_BIT] = ext_irq0_flag;
    end

    // read data one cycle after strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd && hit(reg_addr, POWER_CONTROL_OFS))
            reg_rdata <= pctl_rd;
        else if (reg_rd && hit(reg_addr, TIMER_EXTIRQ_CONTROL_OFS))
            reg_rdata <= tctl_rd;
        else
            reg_rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_t1_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer1_overflow |=> tctl_q[T1_OVF_BIT])
        else $error("timer1 overflow flag not set");
    chk_t0_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer0_overflow |=> tctl_q[T0_OVF_BIT])
        else $error("timer0 overflow flag not set");
    chk_pd_over_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_pctl && reg_wdata[POWER_DOWN_BIT]) |=> !pctl_q[LIGHT_SLEEP_BIT])
        else $error("light sleep set with power-down");
    chk_wake_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wake_event && !wr_pctl) |=> !cpu_clk_stop)
        else $error("wake did not clear sleep bits");
    chk_x1_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tctl_q[X1_TYPE_BIT] |-> ext_irq1_flag == !x1_lvl)
        else $error("irq1 level flag wrong");
    chk_x0_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tctl_q[X0_TYPE_BIT] |-> ext_irq0_flag == !x0_lvl)
        else $error("irq0 level flag wrong");
    chk_x1_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tctl_q[X1_TYPE_BIT] && x1_fall && !wr_tctl) |=> ext_irq1_flag)
        else $error("irq1 edge not flagged");
    chk_x0_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tctl_q[X0_TYPE_BIT] && x0_fall && !wr_tctl) |=> ext_irq0_flag)
        else $error("irq0 edge not flagged");
    chk_run_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_tctl |=> timer1_run == $past(reg_wdata[T1_RUN_BIT]))
        else $error("timer1 run not written");
    chk_idle_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cpu_clk_stop && !periph_clk_stop) |-> pctl_q[LIGHT_SLEEP_BIT])
        else $error("core stopped without sleep");

    cov_power_down: cover property (@(posedge core_clk) periph_clk_stop);
    cov_light_sleep: cover property (@(posedge core_clk)
        cpu_clk_stop && !periph_clk_stop);
    cov_edge_flag: cover property (@(posedge core_clk)
        tctl_q[X0_TYPE_BIT] && x0_fall);

    // ------------------------------------------------------------
    // further checks: power-on, edge, general and run flags, and clock stops
    // ------------------------------------------------------------
    // power-on flag moves only on a write; warm resets keep it
    chk_pof_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_pctl |=> $stable(pof_q))
        else $error("power-on flag changed without write");
    // stored edge flag must be empty while in level mode
    chk_x1_lvl_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tctl_q[X1_TYPE_BIT] |=> !tctl_q[X1_FLAG_BIT])
        else $error("irq1 stored flag kept in level mode");
    chk_x0_lvl_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tctl_q[X0_TYPE_BIT] |=> !tctl_q[X0_FLAG_BIT])
        else $error("irq0 stored flag kept in level mode");
    // general flag at GEN_FLAG_ONE_BIT takes exactly what software wrote
    chk_gen_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_pctl |=> pctl_q[GEN_FLAG_ONE_BIT]
            == $past(reg_wdata[GEN_FLAG_ONE_BIT]))
        else $error("general flag not written");
    chk_t0_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_tctl |=> timer0_run == $past(reg_wdata[T0_RUN_BIT]))
        else $error("timer0 run not written");
    // power-down is a superset of light sleep
    chk_pd_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        periph_clk_stop |-> cpu_clk_stop)
        else $error("peripherals stopped but core running");

    // wake out of the deepest mode, and an irq1 edge capture
    cov_pd_wake: cover property (@(posedge core_clk)
        periph_clk_stop && wake_event);
    cov_x1_edge: cover property (@(posedge core_clk)
        tctl_q[X1_TYPE_BIT] && x1_fall);
endmodule

// [sim/ext_pin_model.sv]
// far-side model: the two external interrupt pins with pull-ups
`timescale 1ns/1ps
module ext_pin_model
(
    input  wire logic core_clk,     // system clock
    input  wire logic pin1_low,     // ask pin 1 to go low
    input  wire logic pin0_low,     // ask pin 0 to go low
    output logic      ext_irq1_pin, // pin 1 level
    output logic      ext_irq0_pin  // pin 0 level
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // idle high through the pull-ups, even before the first edge
    initial
    begin
        ext_irq1_pin = 1'b1;
        ext_irq0_pin = 1'b1;
    end
    // a pull-down lands one clock late, like a slow external gate
    always @(posedge core_clk)
    begin
        ext_irq1_pin <= ~pin1_low;
        ext_irq0_pin <= ~pin0_low;
    end
endmodule

// [sim/power_timer_extirq_control_regs_test.sv]
// bench for the power and timer/external-irq control register bank
`timescale 1ns/1ps
module power_timer_extirq_control_regs_test
    import pwr_tmr_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic       core_clk = 1'b0; // 200 MHz
    logic       rst_n    = 1'b0; // warm reset
    logic       por_n    = 1'b0; // cold reset
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [6:0] pls = 7'h00;     // event pulses, one bit each
    wire        wake = pls[0], t1_ovf = pls[1], t0_ovf = pls[2];
    wire        t1_isr = pls[3], t0_isr = pls[4];
    wire        x1_isr = pls[5], x0_isr = pls[6];
    logic       p1_low = 1'b0, p0_low = 1'b0; // pin requests
    logic       pin1, pin0;
    logic       baud, fe_sel, t1_run, t0_run, x1, x0, cpu_s, per_s;
    int         failures = 0;
    int         tests_run = 0;
    // ------------------------------------------------------------
    // clock, far side and block
    // ------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;
    ext_pin_model i_pins (.core_clk(core_clk), .pin1_low(p1_low),
        .pin0_low(p0_low), .ext_irq1_pin(pin1), .ext_irq0_pin(pin0));
    pwr_tmr_regs #(.ADDR_W(8)) i_dut (.core_clk(core_clk),
        .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer1_overflow(t1_ovf),
        .timer0_overflow(t0_ovf), .timer1_isr_enter(t1_isr),
        .timer0_isr_enter(t0_isr), .ext_irq1_isr_enter(x1_isr),
        .ext_irq0_isr_enter(x0_isr), .wake_event(wake),
        .ext_irq1_pin(pin1), .ext_irq0_pin(pin0),
        .serial_baud_double(baud), .frame_error_access_select(fe_sel),
        .timer1_run(t1_run), .timer0_run(t0_run),
        .ext_irq1_flag(x1), .ext_irq0_flag(x0),
        .cpu_clk_stop(cpu_s), .periph_clk_stop(per_s));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    // 0 wake, 1/2 overflows, 3..6 service entries
    task automatic pulse(input int sel);
        @(posedge core_clk);
        pls[sel] <= 1'b1;
        @(posedge core_clk);
        pls      <= 7'h00;
        #1;
    endtask
    // pins change, then enough edges for the synchroniser
    task automatic pins(input logic l1, input logic l0);
        @(posedge core_clk);
        p1_low <= l1;
        p0_low <= l0;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        rd(POWER_CONTROL_OFS, 8'h10);
        wr(8'h89, 8'hFF);
        rd(8'h89, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_power();
        wr(POWER_CONTROL_OFS, 8'hFC);
        #1 check({6'h00, baud, fe_sel}, 8'h03);
        rd(POWER_CONTROL_OFS, 8'hDC);
        wr(POWER_CONTROL_OFS, 8'h10);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        rd(POWER_CONTROL_OFS, 8'h10);
        wr(POWER_CONTROL_OFS, 8'h00);
        rd(POWER_CONTROL_OFS, 8'h00);
        $display("power control done");
    endtask
    task automatic t_sleep();
        wr(POWER_CONTROL_OFS, 8'h01);
        #1 check({6'h00, cpu_s, per_s}, 8'h02);
        pulse(0);
        check({6'h00, cpu_s, per_s}, 8'h00);
        rd(POWER_CONTROL_OFS, 8'h00);
        wr(POWER_CONTROL_OFS, 8'h03);
        #1 check({6'h00, cpu_s, per_s}, 8'h03);
        rd(POWER_CONTROL_OFS, 8'h02);
        pulse(0);
        rd(POWER_CONTROL_OFS, 8'h00);
        check({6'h00, cpu_s, per_s}, 8'h00);
        $display("sleep modes done");
    endtask
    task automatic t_timer();
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h50);
        #1 check({6'h00, t1_run, t0_run}, 8'h03);
        pulse(1);
        pulse(2);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'hF0);
        pulse(3);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h70);
        pulse(4);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h50);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'hA0);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'hA0);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        #1 check({6'h00, t1_run, t0_run}, 8'h00);
        $display("timer control done");
    endtask
    task automatic t_ext_irq();
        pins(1'b1, 1'b1);
        check({6'h00, x1, x0}, 8'h03);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h0A);
        pins(1'b0, 1'b0);
        check({6'h00, x1, x0}, 8'h00);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h05);
        pins(1'b1, 1'b1);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h0F);
        pins(1'b0, 1'b0);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h0F);
        pulse(5);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h07);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h05);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h05);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h0F);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h0F);
        pulse(6);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h0D);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        wr(TIMER_EXTIRQ_CONTROL_OFS, 8'h0A);
        rd(TIMER_EXTIRQ_CONTROL_OFS, 8'h00);
        $display("external irq done");
    endtask
    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // the scenarios need well under a thousand cycles
    initial
    begin
        #20000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        t_reset();
        t_power();
        t_sleep();
        t_timer();
        t_ext_irq();
        stop_test();
    end
endmodule
